/* include/adcsp_defs.svh */
// Constants for the converter serial port and ready logic.
`ifndef ADCSP_DEFS_SVH
`define ADCSP_DEFS_SVH

// Autoreset window in master-clock cycles.
`define ADCSP_TIMEOUT_CYC 65536
// Cycles after an autoreset before a new transaction is taken.
`define ADCSP_RECOVER_CYC 4
// Further serial clock transitions needed to stay out of autoreset.
`define ADCSP_EDGES_NEEDED 7
// Width of the early ready pulse before a new result, in cycles.
`define ADCSP_READY_PULSE_CYC 16
// Bit position of the timeout enable in the port configuration byte.
`define ADCSP_CFG_TIMEOUT_BIT 3
// Port configuration reset value: timeout disabled.
`define ADCSP_CFG_RESET 8'h00
// Result width and output FIFO depth.
`define ADCSP_DATA_W 32
`define ADCSP_FIFO_DEPTH 32

`endif

/* include/adcsp_pkg.sv */
// Types shared by the converter serial port, its checker and its bench.
package adcsp_pkg;

	// Serial pins as seen by the device.
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} adcsp_pins_in_t;

	// Events from the conversion engine.
	typedef struct packed {
		logic pulse_mode;
		logic conv_start;
		logic pre_ready;
		logic result_valid;
		logic [31:0] result;
	} adcsp_conv_t;

	// Ready pin state machine, one-hot.
	typedef enum logic [2:0] {
		ADCSP_RDY_IDLE = 3'b001,
		ADCSP_RDY_LOW = 3'b010,
		ADCSP_RDY_PULSE = 3'b100
	} adcsp_rdy_state_t;

endpackage

/* hdl/adcsp_fifo.sv */
// Result FIFO between the conversion engine and the serial shifter.
`timescale 1ns/100ps
module adcsp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Write side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Read side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} adcsp_fifo_st_t;

	adcsp_fifo_st_t st;
	adcsp_fifo_st_t next_st;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready = (st.cnt != DEPTH[AW:0]);
	assign out_valid = (st.cnt != '0);
	assign out_data = st.mem[st.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next state of pointers, count and storage.
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		if (push && !pop) begin
			next_st.cnt = st.cnt + 1'b1;
		end else if (pop && !push) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule // adcsp_fifo

/* hdl/adcsp_port.sv */
// Serial host port with chip select, autoreset and data-ready signalling.
`timescale 1ns/100ps
`include "adcsp_defs.svh"

module adcsp_port
	import adcsp_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Serial pins from the host.
	input adcsp_pkg::adcsp_pins_in_t pins,
	// Port configuration byte; bit 3 enables the timeout.
	input wire logic [7:0] port_cfg,
	// Conversion engine events and results.
	input adcsp_pkg::adcsp_conv_t conv,
	output logic conv_in_ready,
	// Dedicated ready output.
	output logic conv_ready_n,
	// Shared data-out and ready pin: value and enable (low drives).
	output logic serial_out_ready_n,
	output logic serial_out_oe_n,
	// Received command bytes for the command decoder.
	output logic [7:0] cmd_byte,
	output logic cmd_valid,
	// Autoreset fired, one-cycle pulse.
	output logic autoreset
);
	import adcsp_pkg::*;

	//--------------------------------------------------------------
	// Constants
	//--------------------------------------------------------------
	localparam logic [16:0] TIMEOUT_CYC = 17'(`ADCSP_TIMEOUT_CYC);
	localparam logic [2:0] RECOVER_CYC = 3'(`ADCSP_RECOVER_CYC);
	localparam logic [3:0] EDGES_NEEDED = 4'(`ADCSP_EDGES_NEEDED);
	localparam logic [4:0] PULSE_CYC = 5'(`ADCSP_READY_PULSE_CYC);
	localparam int DW = `ADCSP_DATA_W;

	//--------------------------------------------------------------
	// State
	//--------------------------------------------------------------
	typedef struct packed {
		logic [1:0] cs_sync;
		logic [1:0] sclk_sync;
		logic [1:0] din_sync;
		logic sclk_prev;
		logic watching;
		logic [16:0] win_cnt;
		logic [3:0] edge_cnt;
		logic [2:0] recover;
		logic autoreset;
		logic [5:0] bit_cnt;
		logic [DW-1:0] shift;
		logic loaded;
		logic [7:0] cmd_sr;
		logic [2:0] cmd_bits;
		logic [7:0] cmd_byte;
		logic cmd_valid;
		logic out_bit;
		logic oe_n;
		adcsp_rdy_state_t rdy_st;
		logic [4:0] pulse_cnt;
		logic rdy_n;
		logic pulse_busy;
	} adcsp_port_st_t;

	adcsp_port_st_t st;
	adcsp_port_st_t next_st;

	logic cs_n_s;
	logic sclk_s;
	logic din_s;
	logic sclk_rise;
	logic sclk_fall;
	logic sclk_any;
	logic port_hold;
	logic timeout_en;
	logic fifo_valid;
	logic fifo_pop;
	logic [DW-1:0] fifo_data;

	// Decode of the timeout enable, used only by the watchdog; recovery counts down regardless.
	function automatic logic cfg_timeout(input logic [7:0] cfg);
		cfg_timeout = cfg[`ADCSP_CFG_TIMEOUT_BIT];
	endfunction

	//--------------------------------------------------------------
	// Synchronised pins and edges
	//--------------------------------------------------------------
	// Only the second stage of each synchroniser is read below.
	assign cs_n_s = st.cs_sync[1];
	assign sclk_s = st.sclk_sync[1];
	assign din_s = st.din_sync[1];
	assign sclk_rise = sclk_s && !st.sclk_prev;
	assign sclk_fall = !sclk_s && st.sclk_prev;
	assign sclk_any = sclk_rise || sclk_fall;
	assign timeout_en = cfg_timeout(port_cfg);
	// Serial logic is held while deselected or recovering.
	assign port_hold = cs_n_s || (st.recover != '0);
	assign fifo_pop = fifo_valid && !st.loaded && !port_hold;

	//--------------------------------------------------------------
	// Result buffer
	//--------------------------------------------------------------
	adcsp_fifo #(
		.WIDTH(DW),
		.DEPTH(`ADCSP_FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(conv.result_valid),
		.in_ready(conv_in_ready),
		.in_data(conv.result),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	//--------------------------------------------------------------
	// Next-state logic
	//--------------------------------------------------------------
	// Watchdog, shifter and ready machine all step in one place.
	always_comb begin
		next_st = st;
		next_st.cs_sync = {st.cs_sync[0], pins.cs_n};
		next_st.sclk_sync = {st.sclk_sync[0], pins.sclk};
		next_st.din_sync = {st.din_sync[0], pins.din};
		next_st.sclk_prev = sclk_s;
		next_st.autoreset = 1'b0;
		next_st.cmd_valid = 1'b0;

		// Recovery countdown after an autoreset.
		if (st.recover != '0) begin
			next_st.recover = st.recover - 1'b1;
		end

		// Autoreset watchdog; a fresh window opens on a rising edge.
		if (!timeout_en || port_hold) begin
			next_st.watching = 1'b0;
			next_st.win_cnt = '0;
			next_st.edge_cnt = '0;
		end else if (!st.watching) begin
			if (sclk_rise) begin
				next_st.watching = 1'b1;
				next_st.win_cnt = '0;
				next_st.edge_cnt = '0;
			end
		end else if (sclk_any && st.edge_cnt == EDGES_NEEDED - 1'b1) begin
			// Seventh edge inside the window: stand down, no reset.
			next_st.watching = 1'b0;
		end else if (st.win_cnt == TIMEOUT_CYC - 1'b1) begin
			next_st.watching = 1'b0;
			next_st.autoreset = 1'b1;
			next_st.recover = RECOVER_CYC;
		end else begin
			next_st.win_cnt = st.win_cnt + 1'b1;
			if (sclk_any) begin
				next_st.edge_cnt = st.edge_cnt + 1'b1;
			end
		end

		// Serial shifter; output tri-stated and reset when deselected.
		if (port_hold || next_st.autoreset) begin
			next_st.oe_n = cs_n_s;
			next_st.bit_cnt = '0;
			next_st.cmd_bits = '0;
			next_st.out_bit = 1'b1;
		end else begin
			next_st.oe_n = 1'b0;
			if (fifo_pop) begin
				next_st.shift = fifo_data;
				next_st.loaded = 1'b1;
			end
			// Between reads, with the clock parked low, the pin mirrors
			// the ready output; the last data bit stands until its fall.
			if (st.bit_cnt == '0 && !sclk_s) begin
				next_st.out_bit = st.rdy_n;
			end
			if (sclk_rise && st.loaded) begin
				// Data changes on the rising edge, MSB first.
				next_st.out_bit = st.shift[DW-1];
				next_st.shift = {st.shift[DW-2:0], 1'b0};
				next_st.bit_cnt = st.bit_cnt + 1'b1;
				if (st.bit_cnt == 6'(DW - 1)) begin
					next_st.loaded = 1'b0;
					next_st.bit_cnt = '0;
				end
			end
			if (sclk_fall) begin
				// Input bits are taken on the falling edge.
				next_st.cmd_sr = {st.cmd_sr[6:0], din_s};
				next_st.cmd_bits = st.cmd_bits + 1'b1;
				if (st.cmd_bits == 3'h7) begin
					next_st.cmd_byte = {st.cmd_sr[6:0], din_s};
					next_st.cmd_valid = 1'b1;
				end
			end
		end

		// Ready machine runs whatever chip select does.
		case (st.rdy_st)
			ADCSP_RDY_IDLE: begin
				if (conv.conv_start) begin
					next_st.rdy_n = 1'b1;
					next_st.pulse_busy = conv.pulse_mode;
				end
				if (conv.result_valid) begin
					next_st.rdy_n = 1'b0;
					next_st.rdy_st = ADCSP_RDY_LOW;
				end
			end
			ADCSP_RDY_LOW: begin
				if (conv.result_valid) begin
					next_st.rdy_n = 1'b0;
					next_st.pulse_busy = 1'b0;
				end else if (conv.conv_start) begin
					next_st.rdy_n = 1'b1;
					next_st.pulse_busy = conv.pulse_mode;
				end else if (!conv.pulse_mode && conv.pre_ready) begin
					next_st.rdy_n = 1'b1;
					next_st.pulse_cnt = PULSE_CYC - 1'b1;
					next_st.rdy_st = ADCSP_RDY_PULSE;
				end else if (!conv.pulse_mode && sclk_fall && !port_hold) begin
					next_st.rdy_n = 1'b1;
				end
			end
			ADCSP_RDY_PULSE: begin
				if (conv.result_valid || st.pulse_cnt == '0) begin
					next_st.rdy_n = 1'b0;
					next_st.rdy_st = ADCSP_RDY_LOW;
				end else begin
					next_st.pulse_cnt = st.pulse_cnt - 1'b1;
				end
			end
			default: begin
				next_st.rdy_st = ADCSP_RDY_IDLE;
				next_st.rdy_n = 1'b1;
			end
		endcase
	end

	//--------------------------------------------------------------
	// State register
	//--------------------------------------------------------------
	// Ready idles high and the shared pin idles released.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st <= '0;
			st.cs_sync <= 2'h3;
			st.rdy_st <= ADCSP_RDY_IDLE;
			st.rdy_n <= 1'b1;
			st.oe_n <= 1'b1;
			st.out_bit <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	//--------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------
	assign conv_ready_n = st.rdy_n;
	assign serial_out_ready_n = st.out_bit;
	assign serial_out_oe_n = st.oe_n;
	assign cmd_byte = st.cmd_byte;
	assign cmd_valid = st.cmd_valid;
	assign autoreset = st.autoreset;
endmodule // adcsp_port

/* verification/adcsp_port_asserts.sv */
// Checker for the serial port and ready pins.
`timescale 1ns/100ps
module adcsp_port_asserts
	import adcsp_pkg::*;
(
	// Watched ports.
	input wire logic mclk,
	input wire logic sys_rst,
	input adcsp_pkg::adcsp_pins_in_t pins,
	input wire logic [7:0] port_cfg,
	input adcsp_pkg::adcsp_conv_t conv,
	input wire logic conv_in_ready,
	input wire logic conv_ready_n,
	input wire logic serial_out_ready_n,
	input wire logic serial_out_oe_n,
	input wire logic cmd_valid,
	input wire logic autoreset
);
	// -----------------
	// Properties.
	// -----------------
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Five samples cover the pin synchroniser plus the output register.
	AST_OE_OFF: assert property (pins.cs_n [*5] |-> serial_out_oe_n)
		else $error("shared pin driven while deselected");
	AST_NO_CMD: assert property (pins.cs_n [*5] |-> !cmd_valid)
		else $error("command taken while deselected");
	AST_RDY_FALL: assert property (
		conv.result_valid && conv_in_ready |=> !conv_ready_n)
		else $error("ready did not fall on a new result");
	AST_PIN_FALL: assert property (
		$fell(conv_ready_n) && !serial_out_oe_n
		|=> !serial_out_ready_n || serial_out_oe_n)
		else $error("shared pin did not follow ready");
	AST_SCLK_RAISE: assert property (
		!conv.pulse_mode && !conv_ready_n && !pins.cs_n && $fell(pins.sclk)
		|-> ##[1:5] conv_ready_n)
		else $error("ready not raised by clock fall");
	AST_PRE_PULSE: assert property (
		conv.pre_ready && !conv.pulse_mode
		|=> conv_ready_n [*8] ##1 conv_ready_n [*7])
		else $error("early ready pulse too short");
	AST_START_HIGH: assert property (
		conv.pulse_mode && conv.conv_start |-> ##[1:2] conv_ready_n)
		else $error("ready not high after start");
	AST_PULSE_HOLD: assert property (
		conv.pulse_mode && !conv_ready_n && !conv.conv_start
		&& !$past(conv.conv_start) |=> !conv_ready_n)
		else $error("ready left low state without start");
	AST_AR_EN: assert property (autoreset |-> port_cfg[3])
		else $error("autoreset while timeout disabled");
	AST_AR_GAP: assert property (autoreset |=> !autoreset [*4])
		else $error("autoreset repeated during recovery");
	cover property ($fell(conv_ready_n));
	cover property (autoreset);
	cover property (cmd_valid);
endmodule // adcsp_port_asserts

bind adcsp_port adcsp_port_asserts chk (.mclk(mclk), .sys_rst(sys_rst),
	.pins(pins), .port_cfg(port_cfg), .conv(conv),
	.conv_in_ready(conv_in_ready), .conv_ready_n(conv_ready_n),
	.serial_out_ready_n(serial_out_ready_n),
	.serial_out_oe_n(serial_out_oe_n), .cmd_valid(cmd_valid),
	.autoreset(autoreset));

/* verification/adcsp_host_model.sv */
// Serial master model standing on the far side of the port.
`timescale 1ns/100ps
module adcsp_host_model (
	// Link pins driven by the host.
	output logic cs_n,
	output logic sclk,
	output logic din,
	// Shared data-out pin and its enable.
	input wire logic dout,
	input wire logic dout_oe_n
);
	logic lvl;
	// A released pin has no pull, so the model shows the inverse value.
	assign lvl = dout_oe_n ? ~dout : dout;
	// Idle with the clock parked low and the data line low.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// Select stays low for the whole transfer and while watching.
	task automatic select(input logic v);
		cs_n = v;
	endtask
	// Shift n bits MSB first at the 125 ns link period.
	task automatic xfer(input logic [31:0] tx, input int n,
		output logic [31:0] rx);
		rx = '0;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b1;
			din = tx[i];
			#62.5;
			sclk = 1'b0;
			rx[i] = lvl;
			#62.5;
		end
		din = 1'b0;
	endtask
endmodule // adcsp_host_model

/* verification/adcsp_port_bench.sv */
// Self-checking bench for the converter serial port.
`timescale 1ns/100ps
module adcsp_port_bench;
	import adcsp_pkg::*;
	logic mclk, sys_rst, cs_n, sclk, din, conv_in_ready, conv_ready_n;
	logic serial_out_ready_n, serial_out_oe_n, cmd_valid, autoreset;
	logic [7:0] port_cfg, cmd_byte;
	logic [31:0] rx;
	logic [7:0] cmds[$];
	adcsp_conv_t conv;
	adcsp_pins_in_t pins;
	int n_mismatch = 0, n_tests = 0, cyc = 0, ar_cnt = 0, ar_cyc = 0;
	assign pins = '{cs_n: cs_n, sclk: sclk, din: din};
	adcsp_port uut (.mclk(mclk), .sys_rst(sys_rst), .pins(pins),
		.port_cfg(port_cfg), .conv(conv), .conv_in_ready(conv_in_ready),
		.conv_ready_n(conv_ready_n), .serial_out_ready_n(serial_out_ready_n),
		.serial_out_oe_n(serial_out_oe_n), .cmd_byte(cmd_byte),
		.cmd_valid(cmd_valid), .autoreset(autoreset));
	adcsp_host_model host (.cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(serial_out_ready_n), .dout_oe_n(serial_out_oe_n));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// One-cycle pulses are caught here; the timeout bounds the whole run.
	always @(posedge mclk) begin
		cyc++;
		if (cmd_valid === 1'b1) cmds.push_back(cmd_byte);
		if (autoreset === 1'b1) begin
			ar_cnt++;
			ar_cyc = cyc;
		end
		if (cyc == 90000) begin
			n_mismatch++;
			summarize();
		end
	end
	// ----------
	// Helpers.
	// ----------
	task automatic chk(input logic [31:0] got, exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic push(input logic [31:0] d);
		conv.result = d;
		conv.result_valid = 1'b1;
		tick(1);
		conv.result_valid = 1'b0;
	endtask
	task automatic summarize();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ----------
	// Scenarios.
	// ----------
	// Deselected: clocks ignored, pin floats, ready still works.
	task automatic t_gate();
		chk({conv_ready_n, serial_out_oe_n, autoreset}, 3'b110, "rst");
		host.xfer(32'hA5, 8, rx);
		tick(10);
		chk(cmds.size(), 0, "gated cmd");
		push(32'hC3A50F96);
		tick(2);
		chk(conv_ready_n, 1'b0, "ready cs high");
		chk(serial_out_oe_n, 1'b1, "oe cs high");
		chk(conv_in_ready, 1'b1, "fifo room");
		host.select(1'b0);
		tick(10);
		host.xfer(32'h5A000000, 32, rx);
		tick(10);
		chk(rx, 32'hC3A50F96, "read data");
		chk(cmds[0], 8'h5A, "cmd byte");
		chk(conv_ready_n, 1'b1, "ready after read");
		$display("test gate done");
	endtask
	// Selected: shared pin falls with ready, idle input reads as command byte 8'h00.
	task automatic t_read();
		cmds.delete();
		push(32'h9E3779B1);
		tick(1);
		chk({conv_ready_n, serial_out_ready_n}, 2'b00, "ready pins");
		host.xfer(32'h0, 32, rx);
		tick(10);
		chk(rx, 32'h9E3779B1, "read data 2");
		chk(cmds[3], 8'h00, "idle cmd");
		$display("test read done");
	endtask
	// Unread result: 16-cycle high pulse ahead of the next one.
	task automatic t_pre();
		int hi;
		hi = 0;
		push(32'h1);
		tick(5);
		conv.pre_ready = 1'b1;
		tick(1);
		conv.pre_ready = 1'b0;
		for (int k = 0; k < 16; k++) begin
			hi += (conv_ready_n === 1'b1);
			if (k < 15) tick(1);
		end
		push(32'h2);
		chk(hi, 16, "pulse width");
		chk(conv_ready_n, 1'b0, "ready next");
		$display("test pre done");
	endtask
	// Pulse mode: high on start, low on result, clocks do not raise it.
	task automatic t_pulse();
		conv.pulse_mode = 1'b1;
		tick(2);
		conv.conv_start = 1'b1;
		tick(1);
		conv.conv_start = 1'b0;
		tick(1);
		chk(conv_ready_n, 1'b1, "start high");
		tick(20);
		chk(conv_ready_n, 1'b1, "busy high");
		push(32'h3);
		chk(conv_ready_n, 1'b0, "result low");
		host.xfer(32'h0, 8, rx);
		tick(5);
		chk(conv_ready_n, 1'b0, "held low");
		conv.pulse_mode = 1'b0;
		$display("test pulse done");
	endtask
	// Window closed by enough edges, then a single clock pulse times out.
	task automatic t_auto();
		int t0;
		port_cfg = 8'h08;
		cmds.delete();
		host.xfer(32'h0, 4, rx);
		tick(100);
		t0 = cyc;
		host.xfer(32'h0, 1, rx);
		for (int i = 0; i < 66000 && ar_cnt == 0; i++) tick(1);
		chk(ar_cnt, 1, "one reset");
		chk((ar_cyc - t0 >= 65536) && (ar_cyc - t0 <= 65556), 1, "ar time");
		tick(4);
		host.xfer(32'h3C, 8, rx);
		tick(10);
		chk(cmds[cmds.size() - 1], 8'h3C, "cmd after reset");
		$display("test auto done");
	endtask
	// Reset for 16 cycles, then run every scenario.
	initial begin
		sys_rst = 1'b1;
		port_cfg = 8'h00;
		conv = '0;
		repeat (16) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		tick(2);
		t_gate();
		t_read();
		t_pre();
		t_pulse();
		t_auto();
		summarize();
	end
endmodule // adcsp_port_bench
